/* File: hw/dtp_pkg.sv */
// dtp_pkg: shared constants and types for the dual timer/divider/pwm block
// assumes a plain address/strobe register port driven from the clk domain
package dtp_pkg;
    localparam int DTP_AW = 4;
    // register indices (byte address = index)
    localparam logic [3:0] DTP_CTRL_LO = 4'h0;
    localparam logic [3:0] DTP_CTRL_HI = 4'h1;
    localparam logic [3:0] DTP_MATCH_LO = 4'h2;
    localparam logic [3:0] DTP_MATCH_HI = 4'h3;
    localparam logic [3:0] DTP_DUTY_LO = 4'h4;
    localparam logic [3:0] DTP_DUTY_HI = 4'h5;
    localparam logic [3:0] DTP_COUNT_LO = 4'h6;
    localparam logic [3:0] DTP_COUNT_HI = 4'h7;
    localparam logic [3:0] DTP_STATUS = 4'h8;
    // control field positions
    localparam int DTP_MODE_LSB = 0;
    localparam int DTP_START_BIT = 3;
    localparam int DTP_CLK_LSB = 4;
    localparam int DTP_FF_INIT_BIT = 7;
    localparam logic [7:0] DTP_CTRL_RST = 8'h00;
    localparam logic [7:0] DTP_MATCH_RST = 8'hFF;
    localparam logic [7:0] DTP_DUTY_RST = 8'hFF;
    localparam logic DTP_FF_RST = 1'b0;
    // prescale: fc/2^11, fc/2^7, fc/2^5, fc/2^3; slow path fs/2^3
    localparam int DTP_PRE_W = 11;
    localparam logic [3:0] DTP_SH_SEL0 = 4'hB;
    localparam logic [3:0] DTP_SH_SEL1 = 4'h7;
    localparam logic [3:0] DTP_SH_SEL2 = 4'h5;
    localparam logic [3:0] DTP_SH_SEL3 = 4'h3;
    localparam logic [3:0] DTP_SH_SLOW = 4'h3;
    // resolution of the fastest choice at 16 MHz fc
    localparam int DTP_RES_FAST_NS = 500;

    typedef enum logic [1:0] {
        DTP_MODE_TIMER = 2'b00,
        DTP_MODE_DIV = 2'b01,
        DTP_MODE_PWM = 2'b10,
        DTP_MODE_CASC = 2'b11
    } dtp_mode_t;

    typedef struct packed {
        logic we;
        logic re;
        logic [3:0] addr;
        logic [7:0] wdata;
    } dtp_bus_t;

    typedef struct packed {
        logic [7:0] count;
        logic ff;
        logic irq;
    } dtp_ch_state_t;
endpackage

/* File: hw/dtp_prescale.sv */
// dtp_prescale: free running prescaler with enable pulses for both timers
// assumes fc_tick and fs_tick are one-cycle enables on clk
`timescale 1ns/1ps
module dtp_prescale
    import dtp_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic fc_tick,
    input wire logic fs_tick,
    input wire logic slow_sel,
    input wire logic [1:0] sel_a,
    input wire logic [1:0] sel_b,
    output logic en_a,
    output logic en_b
);
    typedef struct packed {
        logic [DTP_PRE_W-1:0] fc_cnt;
        logic [2:0] fs_cnt;
    } dtp_pre_t;
    dtp_pre_t st_r, st_nxt;
    logic [DTP_PRE_W:0] fc_wrap;
    logic fs_pulse;

    // a rate 2^k ticks when the low k bits of the count are about to wrap
    function automatic logic pick(input logic [1:0] sel,
                                  input logic [DTP_PRE_W:0] wrap,
                                  input logic slow, input logic fsp);
        logic r;
        r = 1'b0;
        case (sel)
            2'h0: r = slow ? fsp : wrap[DTP_SH_SEL0]; // R21
            2'h1: r = wrap[DTP_SH_SEL1];
            2'h2: r = wrap[DTP_SH_SEL2];
            2'h3: r = wrap[DTP_SH_SEL3];
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    always_comb begin
        st_nxt = st_r;
        // wrap[k] is the tick on which the low k count bits roll over
        fc_wrap = '0;
        fc_wrap[0] = fc_tick;
        for (int i = 1; i <= DTP_PRE_W; i++) begin
            fc_wrap[i] = fc_wrap[i-1] && st_r.fc_cnt[i-1];
        end
        fs_pulse = fs_tick && (st_r.fs_cnt == 3'h7);
        if (fc_tick) begin
            st_nxt.fc_cnt = st_r.fc_cnt + 1'b1;
        end
        if (fs_tick) begin
            st_nxt.fs_cnt = st_r.fs_cnt + 1'b1;
        end
        en_a = pick(sel_a, fc_wrap, slow_sel, fs_pulse);
        en_b = pick(sel_b, fc_wrap, slow_sel, fs_pulse);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule // dtp_prescale

/* File: hw/dtp_timer.sv */
// dtp_timer: two 8-bit timers with divider, pwm and cascaded 16-bit modes
// assumes a register port on clk; fc_tick/fs_tick/slow_mode come from clk
// logic, so they are not synchronised
//
// Behaviour
// R1: divider mode counts, on match toggles flip-flop, clears, raises irq
// R2: divider output is a 50% square wave by equal-length halves
// R3: divider pin is the inverse of the toggle flip-flop
// R4: software presets each flip-flop; reset clears it to zero
// R5: divider match register unbuffered; software avoids changing it running
// R6: stopping a divider timer holds its pin level
// R7: software changes the init bit only after stopping, not together
// R8: software sets the port output latch before using the pins
// R9: pwm toggles on duty match and keeps counting
// R10: pwm overflow toggles again, clears counter, raises irq
// R11: pwm pin is the inverse of the flip-flop, polarity via preset
// R12: duty writes while running stage until irq; stopped loads at once
// R13: duty reads during pwm return the staging register; the code returns the active duty register
// R14: software rewrites duty right after the irq
// R15: stopping a pwm timer holds its pin level
// R16: software stops pwm before stop mode
// R17: cascade mode matches 16-bit count, raises upper irq, clears count
// R18: software writes the 16-bit match low byte then high byte
// R19: software keeps init bits zero in cascade mode
// R20: cascade match registers unbuffered
// R21: source clock fc/2^11, 2^7, 2^5, 2^3; first becomes fs/2^3 when slow
// R22: timer mode counts, on match raises irq and clears
// R23: pwm period is 256 source clocks, duty sets first toggle
`timescale 1ns/1ps
module dtp_timer
    import dtp_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic fc_tick,
    input wire logic fs_tick,
    input wire logic slow_mode,
    input wire logic reg_we,
    input wire logic reg_re,
    input wire logic [DTP_AW-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic divider_out_pin_lo_n,
    output logic divider_out_pin_hi_n,
    output logic pwm_out_pin_lo_n,
    output logic pwm_out_pin_hi_n,
    output logic timer_match_irq_lo,
    output logic upper_timer_irq
);
    typedef struct packed {
        logic [1:0][7:0] ctrl;
        logic [1:0][7:0] match;
        logic [1:0][7:0] duty_stage;
        logic [1:0][7:0] duty_act;
        logic [1:0] dpend;
        logic [1:0][7:0] count;
        logic [1:0] ff;
        logic [1:0] irq;
        logic [1:0] sticky;
        logic [7:0] rdata;
    } dtp_state_t;

    dtp_state_t st_r, st_nxt;
    logic en_a, en_b;
    logic [1:0] en;
    logic [1:0] run;
    logic [1:0] ff_init;
    dtp_mode_t mode [2];
    logic casc;
    logic [15:0] cnt16;

    dtp_prescale u_pre (
        .clk(clk),
        .arst_n(arst_n),
        .fc_tick(fc_tick),
        .fs_tick(fs_tick),
        .slow_sel(slow_mode | st_r.ctrl[1][2]),
        .sel_a(st_r.ctrl[0][DTP_CLK_LSB +: 2]),
        .sel_b(st_r.ctrl[1][DTP_CLK_LSB +: 2]),
        .en_a(en_a),
        .en_b(en_b)
    ); // R21

    // ctrl bit 2 of the upper control is the prescale_select_bit
    always_comb begin
        for (int j = 0; j < 2; j++) begin
            mode[j] = dtp_mode_t'(st_r.ctrl[j][DTP_MODE_LSB +: 2]);
            run[j] = st_r.ctrl[j][DTP_START_BIT];
            ff_init[j] = st_r.ctrl[j][DTP_FF_INIT_BIT];
        end
        casc = (mode[1] == DTP_MODE_CASC);
        en = {en_b, en_a};
        cnt16 = {st_r.count[1], st_r.count[0]};
    end

    always_comb begin
        logic [1:0] stop_edge;
        logic hit16;
        st_nxt = st_r;
        stop_edge = '0;
        hit16 = 1'b0;
        st_nxt.irq = '0;
        st_nxt.rdata = '0;
        // per-timer counting
        for (int j = 0; j < 2; j++) begin
            if (casc) begin
                // lower mode and start ignored; cascade runs on upper start at the lower clock select
            end else if (run[j] && en[j]) begin
                case (mode[j])
                    DTP_MODE_TIMER: begin
                        if (st_r.count[j] == st_r.match[j]) begin // R22
                            st_nxt.count[j] = '0;
                            st_nxt.irq[j] = 1'b1;
                        end else begin
                            st_nxt.count[j] = st_r.count[j] + 1'b1;
                        end
                    end
                    DTP_MODE_DIV: begin
                        // match reg read live: no shadow copy
                        if (st_r.count[j] == st_r.match[j]) begin // R5
                            st_nxt.ff[j] = ~st_r.ff[j]; // R1 R2
                            st_nxt.count[j] = '0; // R1
                            st_nxt.irq[j] = 1'b1; // R1
                        end else begin
                            st_nxt.count[j] = st_r.count[j] + 1'b1; // R1
                        end
                    end
                    DTP_MODE_PWM: begin
                        st_nxt.count[j] = st_r.count[j] + 1'b1; // R9 R23
                        if (st_r.count[j] == 8'hFF) begin
                            st_nxt.ff[j] = ~st_r.ff[j]; // R10
                            st_nxt.irq[j] = 1'b1; // R10
                            st_nxt.count[j] = '0; // R10
                            st_nxt.duty_act[j] = st_r.duty_stage[j]; // R12
                            st_nxt.dpend[j] = 1'b0;
                        end else if (st_r.count[j] == st_r.duty_act[j]) begin
                            st_nxt.ff[j] = ~st_r.ff[j]; // R9
                        end
                    end
                    default: begin
                        st_nxt.count[j] = st_r.count[j];
                    end
                endcase
            end
        end
        // cascaded 16-bit timer
        if (casc && run[1] && en[0]) begin // R17
            hit16 = (cnt16 == {st_r.match[1], st_r.match[0]}); // R20
            if (hit16) begin
                {st_nxt.count[1], st_nxt.count[0]} = 16'h0000; // R17
                st_nxt.irq[1] = 1'b1; // R17
            end else begin
                {st_nxt.count[1], st_nxt.count[0]} = cnt16 + 16'h0001;
            end
        end
        // register writes; ff follows init bit only while stopped
        if (reg_we) begin
            case (reg_addr)
                DTP_CTRL_LO, DTP_CTRL_HI: begin
                    st_nxt.ctrl[reg_addr[0]] = reg_wdata;
                    if (!reg_wdata[DTP_START_BIT] &&
                        !run[reg_addr[0]]) begin
                        st_nxt.ff[reg_addr[0]] =
                            reg_wdata[DTP_FF_INIT_BIT]; // R4 R7
                    end
                    stop_edge[reg_addr[0]] = run[reg_addr[0]] &&
                        !reg_wdata[DTP_START_BIT]; // R6 R15
                    if (reg_wdata[DTP_START_BIT] && !run[reg_addr[0]]) begin
                        st_nxt.count[reg_addr[0]] = '0;
                        if (reg_addr[0] && casc) begin
                            st_nxt.count[0] = '0;
                        end
                    end
                end
                DTP_MATCH_LO, DTP_MATCH_HI: begin
                    st_nxt.match[reg_addr[0]] = reg_wdata; // R5 R20
                end
                DTP_DUTY_LO, DTP_DUTY_HI: begin
                    st_nxt.duty_stage[reg_addr[0]] = reg_wdata;
                    if (!run[reg_addr[0]]) begin
                        st_nxt.duty_act[reg_addr[0]] = reg_wdata; // R12
                    end else begin
                        st_nxt.dpend[reg_addr[0]] = 1'b1; // R12
                    end
                end
                DTP_STATUS: begin
                    st_nxt.sticky = st_r.sticky & ~reg_wdata[1:0];
                end
                default: begin
                    // unmapped writes are dropped
                end
            endcase
        end
        // set wins over a same-cycle status clear
        st_nxt.sticky = st_nxt.sticky | st_nxt.irq;
        // reads: data one cycle later
        if (reg_re) begin
            case (reg_addr)
                DTP_CTRL_LO, DTP_CTRL_HI:
                    st_nxt.rdata = st_r.ctrl[reg_addr[0]];
                DTP_MATCH_LO, DTP_MATCH_HI:
                    st_nxt.rdata = st_r.match[reg_addr[0]];
                DTP_DUTY_LO, DTP_DUTY_HI:
                    // a staged write reads back only after its transfer
                    st_nxt.rdata = st_r.duty_act[reg_addr[0]]; // R13
                DTP_COUNT_LO, DTP_COUNT_HI:
                    st_nxt.rdata = st_r.count[reg_addr[0]];
                DTP_STATUS: st_nxt.rdata = {4'h0, st_r.dpend, st_r.sticky};
                default: st_nxt.rdata = 8'h00;
            endcase
        end
        // a stopping write freezes the flip-flop at its current level, even
        // if a count event lands in the same cycle
        for (int j = 0; j < 2; j++) begin
            if (stop_edge[j]) begin
                st_nxt.ff[j] = st_r.ff[j]; // R6 R15 R16
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '0;
            st_r.ctrl <= {DTP_CTRL_RST, DTP_CTRL_RST};
            st_r.match <= {DTP_MATCH_RST, DTP_MATCH_RST};
            st_r.duty_stage <= {DTP_DUTY_RST, DTP_DUTY_RST};
            st_r.duty_act <= {DTP_DUTY_RST, DTP_DUTY_RST};
            st_r.ff <= {DTP_FF_RST, DTP_FF_RST}; // R4
        end else begin
            st_r <= st_nxt;
        end
    end

    // pins are the flip-flop inverted; mode picks which pin shows it
    always_comb begin
        divider_out_pin_lo_n = ~(st_r.ff[0] &
            (mode[0] == DTP_MODE_DIV)); // R3
        divider_out_pin_hi_n = ~(st_r.ff[1] &
            (mode[1] == DTP_MODE_DIV)); // R3
        pwm_out_pin_lo_n = ~(st_r.ff[0] &
            (mode[0] == DTP_MODE_PWM)); // R11
        pwm_out_pin_hi_n = ~(st_r.ff[1] &
            (mode[1] == DTP_MODE_PWM)); // R11
        timer_match_irq_lo = st_r.irq[0];
        upper_timer_irq = st_r.irq[1];
        reg_rdata = st_r.rdata;
    end
endmodule // dtp_timer

/* File: test/dtp_timer_chk.sv */
// dtp_timer_chk: port-level assertions for the dual timer block
// assumes fc_tick/fs_tick pulse at most once per clk and binds to dtp_timer
`timescale 1ns/1ps
module dtp_timer_chk
    import dtp_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic reg_we,
    input wire logic reg_re,
    input wire logic [DTP_AW-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic divider_out_pin_lo_n,
    input wire logic divider_out_pin_hi_n,
    input wire logic pwm_out_pin_lo_n,
    input wire logic pwm_out_pin_hi_n,
    input wire logic timer_match_irq_lo,
    input wire logic upper_timer_irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // fastest source is fc/2^3, so events sit at least 8 cycles apart
    lo_irq_gap_a: assert property (
        timer_match_irq_lo |=> !timer_match_irq_lo [*7])
        else $error("lower timer event not a spaced pulse");
    hi_irq_gap_a: assert property (
        upper_timer_irq |=> !upper_timer_irq [*7])
        else $error("upper timer event not a spaced pulse");
    lo_pins_excl_a: assert property (
        divider_out_pin_lo_n || pwm_out_pin_lo_n)
        else $error("lower divider and pwm pins both active");
    hi_pins_excl_a: assert property (
        divider_out_pin_hi_n || pwm_out_pin_hi_n)
        else $error("upper divider and pwm pins both active");
    // the lower divider pin may move only on a match event or right after a register write
    div_lo_cause_a: assert property (
        $changed(divider_out_pin_lo_n) |->
        timer_match_irq_lo || $past(timer_match_irq_lo) || $past(reg_we) ||
        $past(reg_we, 2))
        else $error("lower divider pin moved without cause");
    // the bench leaves one idle cycle between two accesses
    match_rdbk_a: assert property (
        (reg_we && reg_addr == DTP_MATCH_LO) ##1 !reg_we ##1
        (reg_re && reg_addr == DTP_MATCH_LO) |=>
        reg_rdata == $past(reg_wdata, 3))
        else $error("match value not effective at once");
    unmapped_rd_a: assert property (
        reg_re && reg_addr > DTP_STATUS |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    rdata_idle_a: assert property (
        !$past(reg_re) |-> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
endmodule // dtp_timer_chk

bind dtp_timer dtp_timer_chk dtp_timer_chk_i (.clk(clk), .arst_n(arst_n),
    .reg_we(reg_we), .reg_re(reg_re), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .divider_out_pin_lo_n(divider_out_pin_lo_n),
    .divider_out_pin_hi_n(divider_out_pin_hi_n),
    .pwm_out_pin_lo_n(pwm_out_pin_lo_n), .pwm_out_pin_hi_n(pwm_out_pin_hi_n),
    .timer_match_irq_lo(timer_match_irq_lo), .upper_timer_irq(upper_timer_irq));

/* File: test/tb.sv */
// tb: directed register-level test of the dual timer block
// assumes fc_tick high every cycle, so fc/2^n ticks every 2^n clocks
`timescale 1ns/1ps
module tb;
    import dtp_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic fc_tick = 1'b1;
    logic fs_tick = 1'b0;
    logic slow_mode = 1'b0;
    logic reg_we = 1'b0;
    logic reg_re = 1'b0;
    logic [DTP_AW-1:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic div_lo_n, div_hi_n, pwm_lo_n, pwm_hi_n, irq_lo, irq_hi;
    logic [1:0] fs_cnt = 2'h0;
    int bad_count = 0;
    int num_checks = 0;
    int n;
    logic [7:0] v;
    logic p;
    logic [1:0] cs;
    int per [6] = '{32, 128, 32, 8, 32, 2048};

    always #5 clk = ~clk;
    // fs at a quarter of clk keeps the slow path short
    always @(posedge clk) begin
        fs_cnt <= fs_cnt + 2'h1;
        fs_tick <= (fs_cnt == 2'h3);
    end

    dtp_timer dtp_timer_i (.clk(clk), .arst_n(arst_n), .fc_tick(fc_tick),
        .fs_tick(fs_tick), .slow_mode(slow_mode), .reg_we(reg_we),
        .reg_re(reg_re), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .divider_out_pin_lo_n(div_lo_n),
        .divider_out_pin_hi_n(div_hi_n), .pwm_out_pin_lo_n(pwm_lo_n),
        .pwm_out_pin_hi_n(pwm_hi_n), .timer_match_irq_lo(irq_lo),
        .upper_timer_irq(irq_hi));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // bus tasks wait for a rising edge before they drive, which leaves an idle cycle between accesses,
    // so a strobe is never lowered and raised in one time step
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_we <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_re <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_re <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic wirq(input logic up, output int k);
        k = 0;
        do begin
            @(posedge clk);
            #1 k++;
        end while ((up ? irq_hi : irq_lo) !== 1'b1 && k < 5000);
        if (k >= 5000) begin
            bad_count++;
            $display("mismatch at %0t event wait %h exp %h", $time, k, 0);
        end
    endtask
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic tend(input string s);
        $display("test %s done", s);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        #500000;
        bad_count++;
        end_of_test();
    end

    initial begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        #1 chk({div_lo_n, div_hi_n, pwm_lo_n, pwm_hi_n, irq_lo, irq_hi},
            16'h003C);
        for (int a = 0; a < 6; a++) begin
            rd(a[3:0], v);
            chk(v, (a < 2) ? 16'h0000 : 16'h00FF);
        end
        rd(4'hC, v);
        chk(v, 16'h0000);
        tend("reset");
        wr(DTP_MATCH_LO, 8'h03);
        rd(DTP_MATCH_LO, v);
        chk(v, 16'h0003);
        wr(DTP_CTRL_LO, 8'h31);
        // port output latches sit outside the block; pins taken as enabled
        wr(DTP_CTRL_LO, 8'h39);
        wirq(1'b0, n);
        wirq(1'b0, n);
        chk(n[15:0], 16'h0020);
        repeat (4) @(posedge clk);
        #1 p = !div_lo_n;
        wirq(1'b0, n);
        chk(n[15:0], 16'h001C);
        repeat (4) @(posedge clk);
        #1 chk(div_lo_n, p);
        wr(DTP_CTRL_LO, 8'h31);
        settle();
        p = div_lo_n;
        repeat (100) @(posedge clk);
        #1 chk(div_lo_n, p);
        wr(DTP_CTRL_LO, 8'hB1);
        settle();
        chk(div_lo_n, 16'h0000);
        wr(DTP_CTRL_LO, 8'h31);
        settle();
        chk(div_lo_n, 16'h0001);
        tend("divider");
        wr(DTP_DUTY_HI, 8'h80);
        wr(DTP_CTRL_HI, 8'h32);
        rd(DTP_DUTY_HI, v);
        chk(v, 16'h0080);
        wr(DTP_CTRL_HI, 8'h3A);
        wirq(1'b1, n);
        wirq(1'b1, n);
        chk(n[15:0], 16'h0800);
        wr(DTP_DUTY_HI, 8'h40);
        rd(DTP_DUTY_HI, v);
        chk(v, 16'h0080);
        wirq(1'b1, n);
        settle();
        chk(pwm_hi_n, 16'h0001);
        n = 2;
        while (pwm_hi_n === 1'b1 && n < 3000) begin
            @(posedge clk);
            #1 n++;
        end
        chk(n >= 500 && n <= 530, 16'h0001);
        wr(DTP_CTRL_HI, 8'h32);
        repeat (1600) @(posedge clk);
        #1 chk(pwm_hi_n, 16'h0000);
        rd(DTP_DUTY_HI, v);
        chk(v, 16'h0040);
        wr(DTP_CTRL_HI, 8'h32);
        settle();
        chk(pwm_hi_n, 16'h0001);
        wr(DTP_CTRL_HI, 8'hB2);
        settle();
        chk(pwm_hi_n, 16'h0000);
        tend("pwm");
        wr(DTP_CTRL_HI, 8'h03);
        wr(DTP_MATCH_LO, 8'h02);
        wr(DTP_MATCH_HI, 8'h01);
        wr(DTP_CTRL_LO, 8'h30);
        wr(DTP_CTRL_HI, 8'h0B);
        wirq(1'b1, n);
        wirq(1'b1, n);
        chk(n[15:0], 16'h0818);
        rd(DTP_MATCH_HI, v);
        chk(v, 16'h0001);
        tend("cascade");
        wr(DTP_CTRL_HI, 8'h03);
        wr(DTP_MATCH_LO, 8'h01);
        for (int i = 0; i < 6; i++) begin
            cs = (i >= 4) ? 2'h0 : i[1:0];
            @(posedge clk);
            slow_mode <= (i == 0);
            wr(DTP_CTRL_HI, (i == 4) ? 8'h04 : 8'h00);
            wr(DTP_CTRL_LO, {2'h0, cs, 4'h0});
            wr(DTP_CTRL_LO, {2'h0, cs, 4'h8});
            wirq(1'b0, n);
            wirq(1'b0, n);
            chk(n[15:0], per[i][15:0] * 16'h0002);
        end
        tend("clock select");
        end_of_test();
    end
endmodule // tb
